// File: bft_map.svh
// Behaviour
// - Current-only: pick-up starts both timers directly
// - Current-only: trips after retrip and backup delays
// - Current-only: timers clear when current drops
// - Current-and-output: timing waits for primary trip
// - Current-and-output: either condition lost resets timers
// - Failed second-coil trip escalates to backup trip
// - Current-or-output: either condition starts timing
// - Current-or-output: reset only when both gone
// - Retrip unused: both timers run, only backup trip asserts
// - Digital-input mode: input drives backup timer
// - ON and OFF events on status changes
// - Per-event mask selects ON, OFF events
// - Resettable counters for trips, starts, blocks
// - Circular log keeps latest twelve records
// - Record holds time, event, currents, remaining times
// - Pick-up releases below 97 percent threshold
// - Block at pick-up gives blocked, no timing
// - Separate retrip, backup delays in 5 ms
// - Retrip disabled never asserts second-coil trip
`ifndef BFT_MAP_SVH
`define BFT_MAP_SVH

`define BFT_CLK_NS      10
`define BFT_TICK_US     5000
`define BFT_LOG_DEPTH   12
`define BFT_HYST_NUM    97
`define BFT_HYST_DEN    100
`define BFT_NUM_EV      8

`define BFT_EV_START    0
`define BFT_EV_RETRIP   1
`define BFT_EV_BACKUP   2
`define BFT_EV_BLOCK    3
`define BFT_EV_OUTMON   4
`define BFT_EV_SIGNAL   5
`define BFT_EV_PHASE    6
`define BFT_EV_RES      7

`endif

// File: bft_pkg.sv
package bft_pkg;
    typedef enum logic [1:0] {
        BFT_MODE_CUR,
        BFT_MODE_CUR_AND_OUT,
        BFT_MODE_CUR_OR_OUT,
        BFT_MODE_INPUT
    } bft_mode_t;
endpackage

// File: bft_log_mem.sv
`timescale 1ns/1ps
module bft_log_mem #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 12,
    parameter int unsigned AW    = 4
) (
    input  wire logic             clk_sys_i, // System clock.
    input  wire logic             wr_en_i,   // Write strobe.
    input  wire logic [AW-1:0]    wr_addr_i, // Write slot.
    input  wire logic [WIDTH-1:0] wr_data_i, // Record to store.
    input  wire logic [AW-1:0]    rd_addr_i, // Read slot.
    output logic      [WIDTH-1:0] rd_data_o  // Registered record.
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    always_ff @(posedge clk_sys_i) begin
        if (wr_en_i) begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem_q[rd_addr_i];
    end
endmodule // bft_log_mem

// File: bft_top.sv
`timescale 1ns/1ps
`include "bft_map.svh"
module bft_top #(
    parameter int unsigned TICK_CYCLES = (`BFT_TICK_US * 1000) / `BFT_CLK_NS,
    parameter int unsigned MAG_W       = 16,
    parameter int unsigned DLY_W       = 19,
    parameter int unsigned CNT_W       = 16,
    parameter int unsigned TS_W        = 32,
    parameter int unsigned GRP_W       = 3
) (
    input  wire logic              clk_sys_i,          // System clock, 100 MHz.
    input  wire logic              rst_b_i,            // Asynchronous reset, active low.
    input  wire bft_pkg::bft_mode_t mode_i,            // Start criterion.
    input  wire logic              retrip_en_i,        // Second-coil stage in use.
    input  wire logic              res_en_i,           // Residual monitoring in use.
    input  wire logic [MAG_W-1:0]  phase_max_mag_i,    // Highest phase current magnitude.
    input  wire logic [MAG_W-1:0]  res_mag_i,          // Residual current magnitude.
    input  wire logic [MAG_W-1:0]  phase_threshold_i,  // Phase pick-up threshold.
    input  wire logic [MAG_W-1:0]  residual_current_threshold_i, // Residual pick-up threshold.
    input  wire logic [DLY_W-1:0]  second_coil_delay_i, // Retrip delay in ticks.
    input  wire logic [DLY_W-1:0]  backup_delay_i,     // Backup delay in ticks.
    input  wire logic              primary_trip_i,     // Monitored primary trip output.
    input  wire logic              dig_in_i,           // Dedicated digital input.
    input  wire logic              block_i,            // Block from blocking matrix.
    input  wire logic [GRP_W-1:0]  setting_group_i,    // Active setting group.
    input  wire logic [7:0]        ev_on_mask_i,       // Pass ON events per status bit.
    input  wire logic [7:0]        ev_off_mask_i,      // Pass OFF events per status bit.
    input  wire logic              cnt_clr_i,          // Clear all counters.
    input  wire logic [3:0]        log_rd_addr_i,      // Log slot to read.
    output logic                   start_o,            // Start indication.
    output logic                   second_coil_trip_o, // Retrip contact.
    output logic                   backup_feeder_trip_o, // Backup feeder contact.
    output logic                   blocked_o,          // Blocked indication.
    output logic                   event_valid_o,      // One-cycle event strobe.
    output logic                   event_on_o,         // Event is ON, else OFF.
    output logic [2:0]             event_code_o,       // Status bit that changed.
    output logic [TS_W-1:0]        event_time_o,       // Event time in ticks.
    output logic [CNT_W-1:0]       retrip_cnt_o,       // Second-coil trip count.
    output logic [CNT_W-1:0]       backup_cnt_o,       // Backup trip count.
    output logic [CNT_W-1:0]       start_cnt_o,        // Start count.
    output logic [CNT_W-1:0]       block_cnt_o,        // Blocked count.
    output logic [3:0]             log_wr_ptr_o,       // Next slot to be written.
    output logic [3:0]             log_count_o,        // Valid records.
    output logic [TS_W+3+4*MAG_W+GRP_W-1:0] log_rd_data_o // Registered record.
);
    localparam int unsigned PW    = MAG_W + 7;
    localparam int unsigned REC_W = TS_W + 3 + 4 * MAG_W + GRP_W;
    localparam int unsigned DIV_W = $clog2(TICK_CYCLES + 1);

    function automatic logic pu_next(input logic cur, input logic [MAG_W-1:0] mag, input logic [MAG_W-1:0] thr);
        logic [PW-1:0] m_scaled;
        logic [PW-1:0] t_scaled;
        m_scaled = PW'(mag) * PW'(`BFT_HYST_DEN);
        t_scaled = PW'(thr) * PW'(`BFT_HYST_NUM);
        if (cur) begin
            return !(m_scaled < t_scaled);
        end
        return mag > thr;
    endfunction

    function automatic logic [7:0] lowest(input logic [7:0] v);
        return v & (~v + 8'h01);
    endfunction

    function automatic logic [2:0] index_of(input logic [7:0] onehot);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = 0; i < 8; i++) begin
            if (onehot[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic [CNT_W-1:0] cnt_next(input logic [CNT_W-1:0] c, input logic inc, input logic clr);
        if (clr) begin
            return inc ? CNT_W'(1) : '0; // Clear with a coincident increment leaves a count of one.
        end
        return inc ? c + CNT_W'(1) : c;
    endfunction

    function automatic logic [DLY_W-1:0] remain(input logic [DLY_W-1:0] dly, input logic [DLY_W-1:0] cnt);
        return (cnt >= dly) ? '0 : dly - cnt;
    endfunction

    // Program tick divider.
    logic [DIV_W-1:0] div_q;
    logic             tick_q;
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (div_q == DIV_W'(TICK_CYCLES - 1));
            div_q  <= (div_q == DIV_W'(TICK_CYCLES - 1)) ? '0 : div_q + DIV_W'(1);
        end
    end

    // Pick-up with fixed hysteresis.
    logic ph_pu_q;
    logic res_pu_q;
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ph_pu_q  <= 1'b0;
            res_pu_q <= 1'b0;
        end else begin
            ph_pu_q  <= pu_next(ph_pu_q, phase_max_mag_i, phase_threshold_i);
            res_pu_q <= res_en_i && pu_next(res_pu_q, res_mag_i, residual_current_threshold_i);
        end
    end

    wire logic cur_pu = ph_pu_q | res_pu_q;
    logic      start_cond;
    always_comb begin
        case (mode_i)
            bft_pkg::BFT_MODE_CUR:         start_cond = cur_pu;
            bft_pkg::BFT_MODE_CUR_AND_OUT: start_cond = cur_pu & primary_trip_i;
            bft_pkg::BFT_MODE_CUR_OR_OUT:  start_cond = cur_pu | primary_trip_i;
            bft_pkg::BFT_MODE_INPUT:       start_cond = dig_in_i;
            default:                       start_cond = 1'b0;
        endcase
    end

    // A block that arrives during a start drops it like a released pick-up, but also raises blocked_o.
    wire logic run     = start_cond & ~block_i;
    wire logic blocked = start_cond & block_i;

    // Both timers share the start, halt and reset term; counts saturate at the delay.
    logic [DLY_W-1:0] ret_cnt_q;
    logic [DLY_W-1:0] bk_cnt_q;
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ret_cnt_q <= '0;
            bk_cnt_q  <= '0;
        end else if (!run) begin
            ret_cnt_q <= '0;
            bk_cnt_q  <= '0;
        end else if (tick_q) begin
            if (ret_cnt_q < second_coil_delay_i) ret_cnt_q <= ret_cnt_q + DLY_W'(1);
            if (bk_cnt_q < backup_delay_i) bk_cnt_q <= bk_cnt_q + DLY_W'(1);
        end
    end

    wire logic retrip_d = run & retrip_en_i & (ret_cnt_q >= second_coil_delay_i);
    wire logic backup_d = run & (bk_cnt_q >= backup_delay_i);

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            start_o              <= 1'b0;
            second_coil_trip_o   <= 1'b0;
            backup_feeder_trip_o <= 1'b0;
            blocked_o            <= 1'b0;
        end else begin
            start_o              <= run;
            second_coil_trip_o   <= retrip_d;
            backup_feeder_trip_o <= backup_d;
            blocked_o            <= blocked;
        end
    end

    // Event detection; pending bits hold changes so none is lost when several coincide.
    wire logic [7:0] status = {res_pu_q, ph_pu_q, dig_in_i, primary_trip_i,
                               blocked_o, backup_feeder_trip_o, second_coil_trip_o, start_o};
    logic [7:0] prev_q;
    logic [7:0] pend_on_q;
    logic [7:0] pend_off_q;
    wire logic [7:0] rise    = status & ~prev_q;
    wire logic [7:0] fall    = ~status & prev_q;
    wire logic [7:0] sel_on  = lowest(pend_on_q);
    wire logic [7:0] sel_off = (|pend_on_q) ? 8'h00 : lowest(pend_off_q);
    wire logic       pick    = |(sel_on | sel_off);
    wire logic [2:0] pick_ix = index_of(sel_on | sel_off);
    wire logic       pass    = |((sel_on & ev_on_mask_i) | (sel_off & ev_off_mask_i));
    logic [TS_W-1:0] ts_q;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prev_q        <= 8'h00;
            pend_on_q     <= 8'h00;
            pend_off_q    <= 8'h00;
            ts_q          <= '0;
            event_valid_o <= 1'b0;
            event_on_o    <= 1'b0;
            event_code_o  <= 3'h0;
            event_time_o  <= '0;
        end else begin
            prev_q        <= status;
            pend_on_q     <= (pend_on_q & ~sel_on) | rise;
            pend_off_q    <= (pend_off_q & ~sel_off) | fall;
            ts_q          <= tick_q ? ts_q + TS_W'(1) : ts_q;
            event_valid_o <= pick & pass;
            event_on_o    <= |sel_on;
            event_code_o  <= pick_ix;
            event_time_o  <= ts_q;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            retrip_cnt_o <= '0;
            backup_cnt_o <= '0;
            start_cnt_o  <= '0;
            block_cnt_o  <= '0;
        end else begin
            retrip_cnt_o <= cnt_next(retrip_cnt_o, rise[`BFT_EV_RETRIP], cnt_clr_i);
            backup_cnt_o <= cnt_next(backup_cnt_o, rise[`BFT_EV_BACKUP], cnt_clr_i);
            start_cnt_o  <= cnt_next(start_cnt_o, rise[`BFT_EV_START], cnt_clr_i);
            block_cnt_o  <= cnt_next(block_cnt_o, rise[`BFT_EV_BLOCK], cnt_clr_i);
        end
    end

    // Every ON event is logged whatever the mask says, since the log is a separate record.
    wire logic             log_we  = |sel_on;
    wire logic [MAG_W-1:0] ret_rem = MAG_W'(remain(second_coil_delay_i, ret_cnt_q));
    wire logic [MAG_W-1:0] bk_rem  = MAG_W'(remain(backup_delay_i, bk_cnt_q));
    wire logic [REC_W-1:0] record  = {ts_q, pick_ix, phase_max_mag_i, res_mag_i,
                                      ret_rem, bk_rem, setting_group_i};

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            log_wr_ptr_o <= 4'h0;
            log_count_o  <= 4'h0;
        end else if (log_we) begin
            log_wr_ptr_o <= (log_wr_ptr_o == 4'(`BFT_LOG_DEPTH - 1)) ? 4'h0 : log_wr_ptr_o + 4'h1;
            if (log_count_o != 4'(`BFT_LOG_DEPTH)) log_count_o <= log_count_o + 4'h1;
        end
    end

    bft_log_mem #(
        .WIDTH (REC_W),
        .DEPTH (`BFT_LOG_DEPTH),
        .AW    (4)
    ) u_log (
        .clk_sys_i (clk_sys_i),
        .wr_en_i   (log_we),
        .wr_addr_i (log_wr_ptr_o),
        .wr_data_i (record),
        .rd_addr_i (log_rd_addr_i),
        .rd_data_o (log_rd_data_o)
    );
endmodule // bft_top

// File: bft_breaker.sv
`timescale 1ns/1ps
module bft_breaker (
    input  wire logic        clk_sys_i,  // Clock.
    input  wire logic        rst_b_i,    // Reset, active low.
    input  wire logic        fault_i,    // Fault present.
    input  wire logic [15:0] mag_i,      // Fault magnitude.
    input  wire logic        cmd_i,      // Primary trip command.
    input  wire logic        coil2_i,    // Second-coil trip.
    input  wire logic        coil2_ok_i, // Second coil works.
    input  wire logic        backup_i,   // Backup feeder trip.
    output logic             trip_o,     // Primary trip output.
    output logic      [15:0] mag_o       // Current seen.
);
    logic open_q;
    // The primary coil is treated as stuck, so only a working second coil or the feeder clears the fault.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) open_q <= 1'b0;
        else open_q <= fault_i && (open_q || backup_i || (coil2_i && coil2_ok_i));
    end
    assign trip_o = cmd_i;
    assign mag_o  = (fault_i && !open_q) ? mag_i : 16'h0000;
endmodule // bft_breaker

// File: bft_chk_asserts.sv
`timescale 1ns/1ps
module bft_chk #(parameter int unsigned CNT_W = 16) (
    input wire logic             clk_sys_i,            // Clock.
    input wire logic             rst_b_i,              // Reset, active low.
    input wire logic             retrip_en_i,          // Retrip in use.
    input wire logic             block_i,              // Block.
    input wire logic             cnt_clr_i,            // Counter clear.
    input wire logic [7:0]       ev_on_mask_i,         // ON mask.
    input wire logic             start_o,              // Start.
    input wire logic             second_coil_trip_o,   // Retrip.
    input wire logic             backup_feeder_trip_o, // Backup trip.
    input wire logic             event_valid_o,        // Event strobe.
    input wire logic             event_on_o,           // Event polarity.
    input wire logic [2:0]       event_code_o,         // Event code.
    input wire logic [CNT_W-1:0] start_cnt_o,          // Start count.
    input wire logic [3:0]       log_wr_ptr_o,         // Log pointer.
    input wire logic [3:0]       log_count_o           // Log fill.
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    a_retrip_off_quiet: assert property (!$past(retrip_en_i) |-> !second_coil_trip_o)
        else $error("second-coil trip while disabled");
    a_block_no_start: assert property ($past(block_i) |-> !start_o)
        else $error("start while blocked");
    a_backup_needs_start: assert property (backup_feeder_trip_o |-> start_o)
        else $error("backup trip without start");
    a_coil_needs_start: assert property (second_coil_trip_o |-> start_o)
        else $error("second-coil trip without start");
    a_start_event_on: assert property ($rose(start_o) && ev_on_mask_i[0] |->
        ##2 (event_valid_o && event_on_o && event_code_o == 3'h0))
        else $error("start ON event missing");
    a_log_ptr_step: assert property (event_valid_o && event_on_o |->
        log_wr_ptr_o == (($past(log_wr_ptr_o) == 4'hB) ? 4'h0 : $past(log_wr_ptr_o) + 4'h1))
        else $error("log pointer did not advance");
    a_log_count_cap: assert property (log_count_o <= 4'hC)
        else $error("log count above depth");
    a_start_count_up: assert property ($rose(start_o) && !cnt_clr_i |=>
        start_cnt_o == CNT_W'($past(start_cnt_o) + 1'b1))
        else $error("start counter did not step");
endmodule // bft_chk

// File: bft_top_bench.sv
`timescale 1ns/1ps
module bft_top_bench;
    localparam int TK = 10;
    logic               clk_sys_i = 1'b0, rst_b_i = 1'b0, retrip_en_i = 1'b1, dig_in_i = 1'b0;
    logic               block_i = 1'b0, cnt_clr_i = 1'b0, fault = 1'b0, cmd = 1'b0, primary_trip_i;
    bft_pkg::bft_mode_t mode_i = bft_pkg::BFT_MODE_CUR;
    logic [15:0]        mag = 16'h0000, phase_max_mag_i, res_mag_i = 16'h0000;
    logic [18:0]        rdly = 19'h0_0002, bdly = 19'h0_0006;
    logic [2:0]         grp = 3'h0, event_code_o;
    logic [3:0]         rd_addr = 4'h0, log_wr_ptr_o, log_count_o;
    logic [7:0]         off_mask = 8'hFF;
    logic               start_o, coil_o, backup_o, blocked_o, event_valid_o, event_on_o;
    logic [31:0]        event_time_o;
    logic [15:0]        retrip_cnt_o, backup_cnt_o, start_cnt_o, block_cnt_o;
    logic [101:0]       log_rd_data_o;
    int                 seed = 32493, fail_count = 0, comparisons = 0, cycles = 0, rd, bd, n, et;
    always #5 clk_sys_i = ~clk_sys_i;
    bft_top #(.TICK_CYCLES(TK)) bft_top_inst (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .mode_i(mode_i),
        .retrip_en_i(retrip_en_i), .res_en_i(1'b1), .phase_max_mag_i(phase_max_mag_i), .res_mag_i(res_mag_i),
        .phase_threshold_i(16'h03E8), .residual_current_threshold_i(16'h7FFF), .second_coil_delay_i(rdly),
        .backup_delay_i(bdly), .primary_trip_i(primary_trip_i), .dig_in_i(dig_in_i), .block_i(block_i),
        .setting_group_i(grp), .ev_on_mask_i(8'hFF), .ev_off_mask_i(off_mask), .cnt_clr_i(cnt_clr_i),
        .log_rd_addr_i(rd_addr), .start_o(start_o), .second_coil_trip_o(coil_o), .backup_feeder_trip_o(backup_o),
        .blocked_o(blocked_o), .event_valid_o(event_valid_o), .event_on_o(event_on_o),
        .event_code_o(event_code_o), .event_time_o(event_time_o), .retrip_cnt_o(retrip_cnt_o),
        .backup_cnt_o(backup_cnt_o), .start_cnt_o(start_cnt_o), .block_cnt_o(block_cnt_o),
        .log_wr_ptr_o(log_wr_ptr_o), .log_count_o(log_count_o), .log_rd_data_o(log_rd_data_o));
    bft_breaker bft_breaker_inst (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .fault_i(fault), .mag_i(mag),
        .cmd_i(cmd), .coil2_i(coil_o), .coil2_ok_i(1'b0), .backup_i(backup_o), .trip_o(primary_trip_i),
        .mag_o(phase_max_mag_i));
    task close_out;
        if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task cyc(input int k);
        repeat (k) @(negedge clk_sys_i);
    endtask
    function automatic logic pick(input int s);
        return (s == 0) ? start_o : (s == 1) ? coil_o : backup_o;
    endfunction
    // Tick phase is unknown to the bench, so a delay of d ticks lands anywhere in one tick window.
    task wait_win(input string nm, input int s, input int d);
        while (n < 3000 && pick(s) !== 1'b1) begin
            cyc(1);
            n++;
        end
        chk(nm, 32'h1, 32'(n >= (d - 1) * TK && n <= d * TK + 4));
    endtask
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            close_out();
        end
    end
    // The stamp counts program ticks since reset; the bench cannot see the tick phase, so one tick of slack is allowed.
    always @(negedge clk_sys_i) begin
        if (rst_b_i && event_valid_o === 1'b1) begin
            et = (cycles - 4) / TK - int'(event_time_o);
            chk("event_time_o", 1, 32'(et == 0 || et == 1));
            if (event_on_o === 1'b0) chk("event_off_mask", 1, 32'(off_mask[event_code_o]));
        end
    end
    initial begin
        cyc(4);
        rst_b_i = 1'b1;
        cyc(1);
        chk("start_o", 0, 32'(start_o));
        rd = 2 + ($random(seed) & 3);
        bd = rd + 4;
        rdly = 19'(rd);
        bdly = 19'(bd);
        grp = 3'($random(seed));
        off_mask = 8'($random(seed));
        res_mag_i = 16'($random(seed)) & 16'h3FFF;
        rd_addr = 4'($random(seed) & 7);
        cnt_clr_i = 1'b1;
        cyc(1);
        cnt_clr_i = 1'b0;
        mag = 16'h03E9 + 16'($random(seed) & 255);
        fault = 1'b1;
        n = 0;
        wait_win("cur_retrip", 1, rd);
        wait_win("cur_backup", 2, bd);
        fault = 1'b0;
        cyc(3);
        chk("cur_clear", 0, 32'({start_o, coil_o, backup_o}));
        chk("start_cnt_o", 1, 32'(start_cnt_o));
        chk("retrip_cnt_o", 1, 32'(retrip_cnt_o));
        chk("backup_cnt_o", 1, 32'(backup_cnt_o));
        mag = 16'h03E9;
        fault = 1'b1;
        cyc(3);
        mag = 16'h03D4;
        cyc(3);
        chk("hyst_hold", 1, 32'(start_o));
        mag = 16'h03C0;
        cyc(3);
        chk("hyst_release", 0, 32'(start_o));
        mode_i = bft_pkg::BFT_MODE_CUR_AND_OUT;
        mag = 16'h03E9;
        cyc(bd * TK + TK);
        chk("and_halt", 0, 32'({coil_o, backup_o}));
        cmd = 1'b1;
        n = 0;
        wait_win("and_retrip", 1, rd);
        cmd = 1'b0;
        cyc(3);
        chk("and_reset", 0, 32'({coil_o, backup_o}));
        cmd = 1'b1;
        n = 0;
        wait_win("and_backup", 2, bd);
        cmd = 1'b0;
        fault = 1'b0;
        cyc(3);
        mode_i = bft_pkg::BFT_MODE_CUR_OR_OUT;
        cmd = 1'b1;
        cyc(3);
        chk("or_start", 1, 32'(start_o));
        fault = 1'b1;
        cyc(1);
        cmd = 1'b0;
        cyc(3);
        chk("or_hold", 1, 32'(start_o));
        fault = 1'b0;
        cyc(3);
        chk("or_reset", 0, 32'(start_o));
        mode_i = bft_pkg::BFT_MODE_CUR;
        retrip_en_i = 1'b0;
        fault = 1'b1;
        n = 0;
        wait_win("backup_only", 2, bd);
        chk("second_coil_trip_o", 0, 32'(coil_o));
        fault = 1'b0;
        cyc(3);
        mode_i = bft_pkg::BFT_MODE_INPUT;
        dig_in_i = 1'b1;
        n = 0;
        wait_win("input_backup", 2, bd);
        dig_in_i = 1'b0;
        cyc(3);
        chk("input_release", 0, 32'(backup_o));
        mode_i = bft_pkg::BFT_MODE_CUR;
        cnt_clr_i = 1'b1;
        block_i = 1'b1;
        fault = 1'b1;
        cyc(1);
        cnt_clr_i = 1'b0;
        cyc(3);
        chk("blocked_o", 1, 32'(blocked_o));
        cyc(bd * TK + TK);
        chk("block_trips", 0, 32'({start_o, backup_o}));
        chk("block_cnt_o", 1, 32'(block_cnt_o));
        fault = 1'b0;
        cyc(2);
        block_i = 1'b0;
        rd_addr = (log_wr_ptr_o == 4'h0) ? 4'hB : log_wr_ptr_o - 4'h1;
        cyc(2);
        chk("log_count_o", 12, 32'(log_count_o));
        chk("log_group", 32'(grp), 32'(log_rd_data_o[2:0]));
        close_out();
    end
endmodule // bft_top_bench
bind bft_top bft_chk #(.CNT_W(CNT_W)) bft_chk_inst (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .retrip_en_i(retrip_en_i), .block_i(block_i), .cnt_clr_i(cnt_clr_i), .ev_on_mask_i(ev_on_mask_i),
    .start_o(start_o), .second_coil_trip_o(second_coil_trip_o), .backup_feeder_trip_o(backup_feeder_trip_o),
    .event_valid_o(event_valid_o), .event_on_o(event_on_o), .event_code_o(event_code_o),
    .start_cnt_o(start_cnt_o), .log_wr_ptr_o(log_wr_ptr_o), .log_count_o(log_count_o));
